// File: design/isa_cycle_timing_controller.sv
// Expansion-bus memory and I/O cycle generator with programmable timing
// Overview of operation
// - Stop mode: fixed lead-off per divisor
// - Sync mode: lead-off range per divisor
// - Stretch mode: fixed lead-off per divisor
// - Range resolved by bus clock phase alignment
// - Extra lead-off field adds 0-3 clocks
// - 16-bit memory strobe: (2+W) bus periods
// - Other strobes: period + low time + W
// - Separate I/O, 8-bit, 16-bit memory waits
// - Wait settings 0-7 set minimum strobe
// - Zero-wait cycle completes in three periods
// - Channel ready low extends the strobe
// - Channel ready ignored for system RAM/ROM
// - Memory read/write use memory strobes
// - Memory chip-select-16 gives one word transfer
// - Otherwise two byte cycles, even first
// - I/O read/write use I/O strobes
// - I/O chip-select-16 gives one word transfer
// - Otherwise two byte I/O cycles, even first
// - Divisor field selects /4, /3, /2
// - Mode field selects stop, sync, stretch
`include "isa_cycle_defines.svh"
module isa_cycle_timing_controller
	import isa_cycle_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic REQ,
	input wire logic REQ_WR,
	input wire logic REQ_IO,
	input wire logic REQ_WORD,
	input wire logic REQ_SYS,
	input wire logic [19:0] REQ_ADDR,
	input wire logic [15:0] REQ_WDATA,
	output logic REQ_BUSY,
	output logic REQ_DONE,
	output logic [15:0] REQ_RDATA,
	output logic BUS_CLK,
	output logic [19:0] BUS_ADDR,
	output logic BHE_N,
	output logic [15:0] BUS_DATA_OUT,
	output logic BUS_DATA_OE,
	input wire logic [15:0] BUS_DATA_IN,
	output logic MEM_RD_N,
	output logic MEM_WR_N,
	output logic IO_RD_N,
	output logic IO_WR_N,
	input wire logic CHAN_READY,
	input wire logic MEMCS16_N,
	input wire logic IOCS16_N
);

	logic [7:0] clk_div_q;
	logic [7:0] bus_mode_q;
	logic [7:0] io_wait_q;
	logic [7:0] mem_wait_q;
	cyc_state_e state_q;
	cnt_t cnt_q;
	logic [1:0] phase_q;
	logic bus_clk_q;
	logic wr_q;
	logic io_q;
	logic word_q;
	logic sys_q;
	logic wide_q;
	logic half_q;
	logic cmd_q;
	logic done_q;
	logic [19:0] addr_q;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	logic [7:0] rd_q;
	logic [1:0] div_sel;
	clk_mode_e mode;
	cnt_t n;
	cnt_t low;
	logic run;
	logic last_phase;
	logic wide_ok;
	logic split;

	// Processor clocks per bus clock period
	function automatic cnt_t div_n(input logic [1:0] d);
		if (d == `DIV_4) begin
			div_n = `N_DIV4;
		end else if (d == `DIV_3) begin
			div_n = `N_DIV3;
		end else begin
			div_n = `N_DIV2;
		end
	endfunction : div_n

	// Bus clock low time; /3 spends two thirds low
	function automatic cnt_t div_low(input logic [1:0] d);
		if (d == `DIV_4) begin
			div_low = `LOW_DIV4;
		end else if (d == `DIV_3) begin
			div_low = `LOW_DIV3;
		end else begin
			div_low = `LOW_DIV2;
		end
	endfunction : div_low

	// Least lead-off; the upper end of a range comes from phase alignment
	function automatic cnt_t lead_base(input clk_mode_e m, input logic [1:0] d,
			input logic m16);
		lead_base = m16 ? 6'd2 : 6'd3;
		if (m == CLK_SYNC) begin
			lead_base = m16 ? 6'd2 : 6'd3;
		end else if (m == CLK_STRETCH) begin
			if (d == `DIV_4) begin
				lead_base = m16 ? 6'd2 : 6'd4;
			end else begin
				lead_base = m16 ? 6'd2 : 6'd3;
			end
		end else begin
			if (d == `DIV_4) begin
				lead_base = m16 ? 6'd3 : 6'd5;
			end else if (d == `DIV_3) begin
				lead_base = m16 ? 6'd3 : 6'd4;
			end else begin
				lead_base = m16 ? 6'd2 : 6'd3;
			end
		end
	endfunction : lead_base

	always_comb begin
		div_sel = clk_div_q[`DIV_HI:`DIV_LO];
		mode = clk_mode_e'(bus_mode_q[`MODE_HI:`MODE_LO]);
		n = div_n(div_sel);
		low = div_low(div_sel);
		run = (mode != CLK_STOP) || (state_q != ST_IDLE);
		last_phase = ({4'h0, phase_q} == n - `ONE_CYC);
		wide_ok = io_q ? (bus_mode_q[`IOCS_EN_BIT] && !IOCS16_N)
			: (bus_mode_q[`MEMCS_EN_BIT] && !MEMCS16_N);
		split = word_q && !wide_q;
	end

	// Register port: writes steer timing, status shows cycle state
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			clk_div_q <= `RST_CLK_DIV;
			bus_mode_q <= `RST_BUS_MODE;
			io_wait_q <= `RST_IO_WAIT;
			mem_wait_q <= `RST_MEM_WAIT;
		end else if (REG_WR) begin
			if (REG_ADDR == `OFS_CLK_DIV) begin
				clk_div_q <= REG_WDATA;
			end else if (REG_ADDR == `OFS_BUS_MODE) begin
				bus_mode_q <= REG_WDATA;
			end else if (REG_ADDR == `OFS_IO_WAIT) begin
				io_wait_q <= REG_WDATA;
			end else if (REG_ADDR == `OFS_MEM_WAIT) begin
				mem_wait_q <= REG_WDATA;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rd_q <= 8'h00;
		end else if (REG_RD) begin
			if (REG_ADDR == `OFS_CLK_DIV) begin
				rd_q <= clk_div_q;
			end else if (REG_ADDR == `OFS_BUS_MODE) begin
				rd_q <= bus_mode_q;
			end else if (REG_ADDR == `OFS_IO_WAIT) begin
				rd_q <= io_wait_q;
			end else if (REG_ADDR == `OFS_MEM_WAIT) begin
				rd_q <= mem_wait_q;
			end else if (REG_ADDR == `OFS_STATUS) begin
				rd_q <= {state_q, half_q, wide_q, cmd_q, REQ_BUSY};
			end else begin
				rd_q <= 8'h00;
			end
		end else begin
			rd_q <= 8'h00;
		end
	end

	// Bus clock divider; stop mode parks it, stretch restarts it at the strobe
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			phase_q <= 2'b00;
			bus_clk_q <= 1'b0;
		end else if (!run) begin
			phase_q <= 2'b00;
			bus_clk_q <= 1'b0;
		end else begin
			if (state_q == ST_LEAD && cnt_q == 6'd0 && mode != CLK_SYNC) begin
				phase_q <= 2'b00;
			end else if (last_phase) begin
				phase_q <= 2'b00;
			end else begin
				phase_q <= phase_q + 2'b01;
			end
			bus_clk_q <= ({4'h0, phase_q} < n - low);
		end
	end

	// Cycle sequencer
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_q <= ST_IDLE;
			cnt_q <= 6'd0;
			cmd_q <= 1'b0;
			done_q <= 1'b0;
			half_q <= 1'b0;
			wide_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (REQ) begin
						half_q <= 1'b0;
						wide_q <= 1'b0;
						cnt_q <= lead_base(mode, div_sel, REQ_WORD && !REQ_IO)
							+ {4'h0, bus_mode_q[`LEAD_HI:`LEAD_LO]}
							- `ONE_CYC;
						state_q <= ST_LEAD;
					end
				end
				ST_LEAD: begin
					if (cnt_q != 6'd0) begin
						cnt_q <= cnt_q - `ONE_CYC;
					end else if (mode != CLK_SYNC || last_phase) begin
						cmd_q <= 1'b1;
						// Width is sampled here, ahead of the second bus state
						wide_q <= word_q && !half_q && wide_ok;
						if (word_q && !half_q && wide_ok && !io_q) begin
							cnt_q <= (`M16_PERIODS
								+ {3'h0, mem_wait_q[`M16W_HI:`M16W_LO]}) * n
								- `ONE_CYC;
						end else if (io_q) begin
							cnt_q <= n + low + {3'h0, io_wait_q[`IOW_HI:`IOW_LO]} * n
								- `ONE_CYC;
						end else begin
							cnt_q <= n + low + {3'h0, mem_wait_q[`M8W_HI:`M8W_LO]} * n
								- `ONE_CYC;
						end
						state_q <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (cnt_q != 6'd0) begin
						cnt_q <= cnt_q - `ONE_CYC;
					end else if (sys_q || CHAN_READY) begin
						cmd_q <= 1'b0;
						// Recovery pads a zero-wait cycle out to three periods
						cnt_q <= (n > low) ? n - low - `ONE_CYC : 6'd0;
						state_q <= ST_RECOV;
					end
				end
				ST_RECOV: begin
					if (cnt_q != 6'd0) begin
						cnt_q <= cnt_q - `ONE_CYC;
					end else if (split && !half_q) begin
						half_q <= 1'b1;
						cnt_q <= lead_base(mode, div_sel, 1'b0)
							+ {4'h0, bus_mode_q[`LEAD_HI:`LEAD_LO]} - `ONE_CYC;
						state_q <= ST_LEAD;
					end else begin
						done_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Request capture and address/data lanes
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wr_q <= 1'b0;
			io_q <= 1'b0;
			word_q <= 1'b0;
			sys_q <= 1'b0;
			addr_q <= 20'h00000;
			wdata_q <= 16'h0000;
		end else if (state_q == ST_IDLE && REQ) begin
			wr_q <= REQ_WR;
			io_q <= REQ_IO;
			word_q <= REQ_WORD;
			sys_q <= REQ_SYS;
			addr_q <= REQ_ADDR;
			wdata_q <= REQ_WDATA;
		end else if (state_q == ST_RECOV && cnt_q == 6'd0 && split && !half_q) begin
			addr_q <= addr_q | 20'h00001;
			wdata_q <= {wdata_q[15:8], wdata_q[15:8]};
		end
	end

	// Read data; the odd byte of a split cycle arrives on the low lane
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rdata_q <= 16'h0000;
		end else if (state_q == ST_CMD && cnt_q == 6'd0 && (sys_q || CHAN_READY)
				&& !wr_q) begin
			if (wide_q) begin
				rdata_q <= BUS_DATA_IN;
			end else if (half_q) begin
				rdata_q <= {BUS_DATA_IN[7:0], rdata_q[7:0]};
			end else begin
				rdata_q <= {8'h00, BUS_DATA_IN[7:0]};
			end
		end
	end

	// PC Card strobe delay lives in the card controller, not here
	assign BUS_CLK = bus_clk_q;
	assign BUS_ADDR = addr_q;
	assign BHE_N = !(wide_q || addr_q[0] || (word_q && !half_q));
	assign BUS_DATA_OUT = wdata_q;
	assign BUS_DATA_OE = wr_q && (state_q != ST_IDLE);
	assign MEM_RD_N = !(cmd_q && !io_q && !wr_q);
	assign MEM_WR_N = !(cmd_q && !io_q && wr_q);
	assign IO_RD_N = !(cmd_q && io_q && !wr_q);
	assign IO_WR_N = !(cmd_q && io_q && wr_q);
	assign REQ_BUSY = (state_q != ST_IDLE);
	assign REQ_DONE = done_q;
	assign REQ_RDATA = rdata_q;
	assign REG_RDATA = rd_q;

endmodule : isa_cycle_timing_controller

// File: include/isa_cycle_defines.svh
// Register offsets, field positions, reset values and timing figures
`ifndef ISA_CYCLE_DEFINES_SVH
`define ISA_CYCLE_DEFINES_SVH
`define OFS_CLK_DIV 8'h01
`define OFS_BUS_MODE 8'h34
`define OFS_IO_WAIT 8'h35
`define OFS_MEM_WAIT 8'h36
`define OFS_STATUS 8'h37
`define RST_CLK_DIV 8'h02
`define RST_BUS_MODE 8'h00
`define RST_IO_WAIT 8'h00
`define RST_MEM_WAIT 8'h00
`define DIV_LO 0
`define DIV_HI 1
`define MODE_LO 6
`define MODE_HI 7
`define LEAD_LO 0
`define LEAD_HI 1
`define IOCS_EN_BIT 4
`define MEMCS_EN_BIT 5
`define IOW_LO 0
`define IOW_HI 2
`define M8W_LO 0
`define M8W_HI 2
`define M16W_LO 4
`define M16W_HI 6
`define DIV_4 2'b00
`define DIV_3 2'b01
`define N_DIV4 6'd4
`define N_DIV3 6'd3
`define N_DIV2 6'd2
`define LOW_DIV4 6'd2
`define LOW_DIV3 6'd2
`define LOW_DIV2 6'd1
`define M16_PERIODS 6'd2
`define ZERO_WAIT_PERIODS 6'd3
`define ONE_CYC 6'd1
`endif

// File: include/isa_cycle_pkg.sv
// Types shared by the expansion-bus cycle controller
package isa_cycle_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LEAD = 4'b0010,
		ST_CMD = 4'b0100,
		ST_RECOV = 4'b1000
	} cyc_state_e;
	typedef enum logic [1:0] {
		CLK_STOP = 2'b00,
		CLK_SYNC = 2'b01,
		CLK_STRETCH = 2'b10,
		CLK_RSVD = 2'b11
	} clk_mode_e;
	typedef logic [5:0] cnt_t;
endpackage : isa_cycle_pkg

// File: bench/isa_cycle_props.sv
// Checker for strobe timing and command selection
module isa_cycle_props (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic REQ,
	input wire logic REQ_WR,
	input wire logic REQ_IO,
	input wire logic REQ_SYS,
	input wire logic REQ_BUSY,
	input wire logic BUS_DATA_OE,
	input wire logic MEM_RD_N,
	input wire logic MEM_WR_N,
	input wire logic IO_RD_N,
	input wire logic IO_WR_N,
	input wire logic CHAN_READY
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	logic wr_q;
	logic io_q;
	logic sys_q;
	wire slo = !(MEM_RD_N && MEM_WR_N && IO_RD_N && IO_WR_N);
	// Request kind is kept here because the request inputs may drop after the request cycle
	always_ff @(posedge CORE_CLK) begin
		if (REQ && !REQ_BUSY) begin
			wr_q <= REQ_WR;
			io_q <= REQ_IO;
			sys_q <= REQ_SYS;
		end
	end
	sequence s_quiet; !slo [*2]; endsequence
	sequence s_held; slo [*3]; endsequence
	property p_lead; $rose(REQ_BUSY) |-> s_quiet; endproperty
	a_lead: assert property (p_lead) else $error("strobe too early");
	property p_width; $rose(slo) |-> s_held; endproperty
	a_width: assert property (p_width) else $error("strobe too short");
	property p_one; $onehot0({!MEM_RD_N, !MEM_WR_N, !IO_RD_N, !IO_WR_N}); endproperty
	a_one: assert property (p_one) else $error("two strobes at once");
	property p_mrd; !MEM_RD_N |-> !io_q && !wr_q; endproperty
	a_mrd: assert property (p_mrd) else $error("wrong memory read strobe");
	property p_iowr; !IO_WR_N |-> io_q && wr_q; endproperty
	a_iowr: assert property (p_iowr) else $error("wrong io write strobe");
	property p_oe; !(MEM_RD_N && IO_RD_N) |-> !BUS_DATA_OE; endproperty
	a_oe: assert property (p_oe) else $error("data driven during read");
	property p_rdy; slo && !CHAN_READY && !sys_q |=> slo; endproperty
	a_rdy: assert property (p_rdy) else $error("strobe ended while not ready");
	property p_sys; $rose(slo) && sys_q |-> ##[3:40] !slo; endproperty
	a_sys: assert property (p_sys) else $error("system cycle held by ready");
endmodule : isa_cycle_props
bind isa_cycle_timing_controller isa_cycle_props u_props (.CORE_CLK, .RST, .REQ, .REQ_WR,
	.REQ_IO, .REQ_SYS, .REQ_BUSY, .BUS_DATA_OE, .MEM_RD_N, .MEM_WR_N, .IO_RD_N, .IO_WR_N,
	.CHAN_READY);

// File: bench/isa_periph_model.sv
// Expansion peripheral: read data, chip-select-16 and channel ready
module isa_periph_model (
	input wire logic clk,
	input wire logic [19:0] addr,
	input wire logic rd_n,
	input wire logic any_n,
	input wire logic wide,
	input wire logic [3:0] hold,
	output logic [15:0] dq,
	output logic rdy,
	output logic cs16_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] cnt = 6'h00;
	logic [15:0] last = 16'h0000;
	always_ff @(posedge clk) begin
		cnt <= any_n ? 6'h00 : cnt + 6'h01;
		if (!rd_n) last <= dq;
	end
	// Released lines show the inverse so a stale sample cannot match
	assign dq = rd_n ? ~last : {addr[7:0] ^ 8'h5a, addr[7:0]};
	assign rdy = any_n || cnt >= 6'(hold);
	assign cs16_n = !wide;
endmodule : isa_periph_model

// File: bench/tb_top.sv
// Self-checking bench for the expansion-bus cycle controller
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic CORE_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, REQ = 1'b0;
	logic REQ_WR = 1'b0, REQ_IO = 1'b0, REQ_WORD = 1'b0, REQ_SYS = 1'b0, wide = 1'b1;
	logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
	logic [19:0] REQ_ADDR = 20'h0, BUS_ADDR, ld, w, ns, a0, a1;
	logic [15:0] REQ_WDATA = 16'hc3a5, REQ_RDATA, BUS_DATA_OUT, BUS_DATA_IN;
	logic REQ_BUSY, REQ_DONE, BUS_CLK, BHE_N, BUS_DATA_OE, CHAN_READY, MEMCS16_N;
	logic MEM_RD_N, MEM_WR_N, IO_RD_N, IO_WR_N, IOCS16_N, pv;
	logic [3:0] hold = 4'h0;
	int err_total = 0, checked = 0;
	// div, mode, extra, io, write, word, wait, lead, width
	// Last row: reserved divisor and mode codes fall back to /2 and stop timing
	int rows [9][9] = '{'{2,0,0,1,1,0,0,3,3}, '{0,0,1,1,0,0,2,6,14}, '{1,0,2,0,0,0,1,6,8},
		'{0,0,3,0,1,1,3,6,20}, '{0,2,0,0,1,0,0,4,6}, '{2,2,0,0,0,1,0,2,4},
		'{1,2,1,1,0,0,0,4,5}, '{2,0,0,1,0,1,0,3,3}, '{3,3,0,1,0,0,0,3,3}};
	wire slo = !(MEM_RD_N & MEM_WR_N & IO_RD_N & IO_WR_N);
	assign IOCS16_N = MEMCS16_N;
	always #10 CORE_CLK = ~CORE_CLK;
	isa_cycle_timing_controller dut (.CORE_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
		.REG_RDATA, .REQ, .REQ_WR, .REQ_IO, .REQ_WORD, .REQ_SYS, .REQ_ADDR, .REQ_WDATA,
		.REQ_BUSY, .REQ_DONE, .REQ_RDATA, .BUS_CLK, .BUS_ADDR, .BHE_N, .BUS_DATA_OUT,
		.BUS_DATA_OE, .BUS_DATA_IN, .MEM_RD_N, .MEM_WR_N, .IO_RD_N, .IO_WR_N, .CHAN_READY,
		.MEMCS16_N, .IOCS16_N);
	isa_periph_model pm (.clk(CORE_CLK), .addr(BUS_ADDR), .rd_n(MEM_RD_N & IO_RD_N),
		.any_n(!slo), .wide(wide), .hold(hold), .dq(BUS_DATA_IN), .rdy(CHAN_READY),
		.cs16_n(MEMCS16_N));
	task automatic chk(string n, logic [19:0] s, logic [19:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	task automatic wreg(logic [7:0] a, logic [7:0] d);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask : wreg
	task automatic rreg(logic [7:0] a, logic [7:0] e);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1;
		chk("reg", 20'(REG_RDATA), 20'(e));
	endtask : rreg
	// Counts lead, first strobe width and strobe count until done
	task automatic run(logic io, logic wr, logic wd, logic sy);
		@(posedge CORE_CLK);
		REQ <= 1'b1;
		REQ_IO <= io;
		REQ_WR <= wr;
		REQ_WORD <= wd;
		REQ_SYS <= sy;
		REQ_ADDR <= 20'h00a40;
		@(posedge CORE_CLK);
		REQ <= 1'b0;
		#1;
		ld = '0;
		w = '0;
		ns = '0;
		pv = 1'b0;
		for (int i = 0; i < 300; i++) begin
			if (REQ_DONE === 1'b1) return;
			if (slo && !pv && ns == 0) a0 = BUS_ADDR;
			if (slo && !pv && ns == 1) a1 = BUS_ADDR;
			if (slo && !pv) ns++;
			if (!slo && ns == 0) ld++;
			if (slo && ns == 1) w++;
			pv = slo;
			@(posedge CORE_CLK);
			#1;
		end
		chk("done", 20'h0, 20'h1);
		end_of_test();
	endtask : run
	initial begin
		logic [7:0] ra [5] = '{8'h01, 8'h34, 8'h35, 8'h36, 8'h10};
		logic [7:0] rv [5] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (10) @(posedge CORE_CLK);
		RST <= 1'b0;
		foreach (ra[i]) rreg(ra[i], rv[i]);
		wreg(8'h10, 8'hff);
		wreg(8'h35, 8'h05);
		rreg(8'h35, 8'h05);
		rreg(8'h10, 8'h00);
		foreach (rows[i]) begin
			wreg(8'h01, 8'(rows[i][0]));
			wreg(8'h34, 8'(rows[i][1] * 64 + 48 + rows[i][2]));
			wreg(8'h35, 8'(rows[i][6]));
			wreg(8'h36, 8'(rows[i][6] * 17));
			run(1'(rows[i][3]), 1'(rows[i][4]), 1'(rows[i][5]), 1'b0);
			chk("lead", ld, 20'(rows[i][7]));
			chk("width", w, 20'(rows[i][8]));
			chk("count", ns, 20'h1);
			chk("bhe", 20'(BHE_N), 20'(rows[i][5] == 0));
			chk("oe", 20'(BUS_DATA_OE), 20'h0);
			if (rows[i][4] == 1) chk("wdata", 20'(BUS_DATA_OUT), 20'h0c3a5);
			if (rows[i][4] == 0) chk("rdata", 20'(REQ_RDATA[7:0]), 20'h40);
			if (rows[i][4] == 0 && rows[i][5] == 1) chk("hi", 20'(REQ_RDATA[15:8]), 20'h1a);
		end
		wreg(8'h01, 8'h02);
		wreg(8'h34, 8'h20);
		wreg(8'h35, 8'h00);
		wreg(8'h36, 8'h00);
		run(1'b1, 1'b0, 1'b1, 1'b0);
		chk("count", ns, 20'h2);
		chk("even", a0, 20'h00a40);
		chk("odd", a1, 20'h00a41);
		chk("rdata", 20'(REQ_RDATA), 20'h04140);
		wide <= 1'b0;
		wreg(8'h34, 8'h30);
		run(1'b0, 1'b0, 1'b1, 1'b0);
		chk("count", ns, 20'h2);
		chk("odd", a1, 20'h00a41);
		wide <= 1'b1;
		hold <= 4'h8;
		run(1'b1, 1'b0, 1'b0, 1'b0);
		chk("hold", 20'(w >= 9), 20'h1);
		run(1'b0, 1'b0, 1'b0, 1'b1);
		chk("sys", w, 20'h3);
		hold <= 4'h0;
		wreg(8'h34, 8'h40);
		run(1'b1, 1'b0, 1'b0, 1'b0);
		chk("sync", 20'(ld >= 3 && ld <= 4), 20'h1);
		// Reset between cycles, after run has returned, while the bus clock runs free in sync mode
		wreg(8'h36, 8'h55);
		@(posedge CORE_CLK);
		RST <= 1'b1;
		@(posedge CORE_CLK);
		RST <= 1'b0;
		#1;
		chk("rst_busy", 20'(REQ_BUSY), 20'h0);
		chk("rst_bclk", 20'(BUS_CLK), 20'h0);
		chk("rst_rdata", 20'(REG_RDATA), 20'h0);
		rreg(8'h34, 8'h00);
		rreg(8'h36, 8'h00);
		rreg(8'h37, 8'h10);
		chk("stop_bclk", 20'(BUS_CLK), 20'h0);
		run(1'b1, 1'b0, 1'b0, 1'b0);
		chk("lead", ld, 20'h3);
		chk("width", w, 20'h3);
		end_of_test();
	end
endmodule : tb_top
